// File: design/flash_seq.sv
// Flash command sequencer with erase, protection, vector redirection and security.
// How it works
// - Protected sector sets violation and stays idle; finished erase sets complete flag.
// - Mass erase with any protection sets violation; otherwise erase then complete.
// - Access error blocks all commands until software writes one to clear it.
// - Address write before the divider was ever written raises access error.
// - Address write while the buffer is not empty raises access error.
// - Second address or second command write before launch raises access error.
// - Only command after address, only launch after command; else access error, but a launch write while idle or running is ignored.
// - Only the five known command codes are accepted; others raise access error.
// - Stop during a running operation aborts it and raises access error.
// - Secured debug writes of program, burst or sector codes raise access error.
// - Writing zero to buffer empty flag mid sequence raises access error.
// - Protected region starts above protect select bits followed by nine ones.
// - Protection holds only while the disable bit is zero.
// - Protection loads from nonvolatile byte; only debug writes may change it.
// - Partial protection with redirection enabled moves interrupt vectors below boundary.
// - Secured chip drops untrusted flash writes and reads back zero.
// - Security code 1:0 is open; every other value is secured.
// - Eight matching key bytes in order from secure code unlock until reset.
// - Blank check of a fully erased array unlocks until reset.
// - Complete flag clears on a launch without violation and sets when no command runs.
//
// Implementation choice: the APB slave port.
`default_nettype none
`include "flash_seq_params.svh"
module flash_seq #(
    parameter logic [15:0] ARRAY_BASE   = `ARRAY_BASE_DEF,
    parameter int          SECTOR_TICKS = `SECTOR_TICKS_DEF,
    parameter int          MASS_TICKS   = `MASS_TICKS_DEF,
    parameter int          PROG_TICKS   = `PROG_TICKS_DEF,
    parameter int          BURST_TICKS  = `BURST_TICKS_DEF,
    parameter int          VERIFY_TICKS = `VERIFY_TICKS_DEF
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [17:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        DEBUG_I,
    input  wire logic        SECURE_SRC_I,
    input  wire logic        STOP_I,
    input  wire logic        BLANK_I,
    input  wire logic [7:0]  NV_PROT_I,
    input  wire logic [7:0]  NV_OPT_I,
    input  wire logic [63:0] NV_KEY_I,
    input  wire logic [15:0] VEC_ADDR_I,
    output logic      [15:0] VEC_ADDR_O,
    output logic      [7:0]  ARRAY_CMD_O,
    output logic      [15:0] ARRAY_ADDR_O,
    output logic             SECURED_O
);
    localparam logic [15:0] key_base = `KEY_BASE;

    flash_seq_pkg::seq_state_t state;
    logic [7:0]  divider;
    logic [7:0]  working_options_register;
    logic [7:0]  working_protection_register;
    logic        key_access_bit;
    logic        accerr;
    logic        pviol;
    logic        blank;
    logic        unlocked;
    logic        loaded;
    logic [7:0]  cmd;
    logic [15:0] faddr;
    logic [3:0]  key_idx;
    logic        key_ok;
    logic [8:0]  pre_cnt;
    logic [14:0] run_cnt;
    logic [2:0]  stop_q;
    logic [2:0]  blank_q;
    logic        stop_s;
    logic        blank_s;

    function automatic logic cmd_valid(input logic [7:0] c);
        return c == `CMD_VERIFY || c == `CMD_PROGRAM || c == `CMD_BURST
            || c == `CMD_SECTOR || c == `CMD_MASS;
    endfunction

    function automatic logic [7:0] key_byte(input logic [63:0] k, input logic [2:0] i);
        return k[8 * (7 - int'(i)) +: 8];
    endfunction

    // Three flip-flop synchronisers; a change counts once stages two and three agree.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            stop_q  <= 3'h0;
            blank_q <= 3'h0;
            stop_s  <= 1'b0;
            blank_s <= 1'b0;
        end else begin
            stop_q  <= {stop_q[1:0], STOP_I};
            blank_q <= {blank_q[1:0], BLANK_I};
            if (stop_q[1] == stop_q[2]) begin
                stop_s <= stop_q[2];
            end
            if (blank_q[1] == blank_q[2]) begin
                blank_s <= blank_q[2];
            end
        end
    end

    logic acc;
    logic wr;
    logic w_div;
    logic w_cfg;
    logic w_prot;
    logic w_stat;
    logic w_cmd;
    logic w_addr;
    logic mapped;
    logic trusted;
    logic secured;
    logic in_seq;
    logic key_hit;
    logic drop;
    logic any_prot;
    logic full_prot;
    logic err_addr;
    logic err_cmd;
    logic err_ctrl;
    logic err_stat;
    logic err_stop;
    logic err_any;
    logic launch;
    logic viol;
    logic start;
    logic tick;
    logic done;

    assign acc      = PSEL_I & PENABLE_I & PREADY_O;
    assign wr       = acc & PWRITE_I;
    assign mapped   = PADDR_I == `OFS_DIVIDER || PADDR_I == `OFS_OPTIONS
                   || PADDR_I == `OFS_CONFIG || PADDR_I == `OFS_PROTECT
                   || PADDR_I == `OFS_STATUS || PADDR_I == `OFS_COMMAND
                   || PADDR_I == `OFS_FLASH_ADDR || PADDR_I == {`IDX_NV_PROT, 2'b00}
                   || PADDR_I == {`IDX_NV_OPT, 2'b00};
    assign w_div    = wr & (PADDR_I == `OFS_DIVIDER);
    assign w_cfg    = wr & (PADDR_I == `OFS_CONFIG);
    assign w_prot   = wr & (PADDR_I == `OFS_PROTECT);
    assign w_stat   = wr & (PADDR_I == `OFS_STATUS);
    assign w_cmd    = wr & (PADDR_I == `OFS_COMMAND);
    assign w_addr   = wr & (PADDR_I == `OFS_FLASH_ADDR);
    assign trusted  = SECURE_SRC_I & ~DEBUG_I;
    assign secured  = (working_options_register[1:0] != `SEC_OPEN) & ~unlocked;
    assign in_seq   = state == flash_seq_pkg::SEQ_ADDR || state == flash_seq_pkg::SEQ_CMD;
    assign key_hit  = key_access_bit & (PWDATA_I[15:3] == key_base[15:3]);
    assign drop     = secured & ~SECURE_SRC_I & ~DEBUG_I;
    assign any_prot  = ~working_protection_register[0] & (working_protection_register[7:1] != `ALL_FPS);
    assign full_prot = ~working_protection_register[0] & ({working_protection_register[7:1], `LOW_ONES} < ARRAY_BASE);
    assign err_addr = w_addr & ~key_hit & ~drop & ~accerr
                    & (~divider[`BIT_DIVLD] | state != flash_seq_pkg::SEQ_IDLE);
    assign err_cmd  = w_cmd & (state != flash_seq_pkg::SEQ_ADDR | ~cmd_valid(PWDATA_I[7:0])
                    | (DEBUG_I & secured & (PWDATA_I[7:0] == `CMD_PROGRAM
                    | PWDATA_I[7:0] == `CMD_BURST | PWDATA_I[7:0] == `CMD_SECTOR)));
    assign err_ctrl = (w_div | w_cfg | w_prot) & in_seq;
    assign err_stat = w_stat & in_seq
                    & (state == flash_seq_pkg::SEQ_ADDR | ~PWDATA_I[`BIT_CBEF]);
    assign err_stop = stop_s & (state == flash_seq_pkg::SEQ_RUN);
    assign err_any  = err_addr | err_cmd | err_ctrl | err_stat | err_stop;
    assign launch   = w_stat & PWDATA_I[`BIT_CBEF] & (state == flash_seq_pkg::SEQ_CMD);
    assign viol     = launch & ((cmd == `CMD_MASS) ? any_prot
                    : (cmd != `CMD_VERIFY & ~working_protection_register[0] & (faddr[15:9] > working_protection_register[7:1])));
    assign start    = launch & ~viol;
    assign tick     = pre_cnt == (divider[`BIT_PRDIV8] ? {divider[5:0], 3'b111}
                                                      : {3'b000, divider[5:0]});
    assign done     = (state == flash_seq_pkg::SEQ_RUN) & tick & (run_cnt == 15'h0000)
                    & ~err_stop;

    // Timing tick prescaler.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pre_cnt <= 9'h000;
        end else if (tick || state != flash_seq_pkg::SEQ_RUN) begin
            pre_cnt <= 9'h000;
        end else begin
            pre_cnt <= pre_cnt + 9'h001;
        end
    end

    // Command sequence and array operation.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state   <= flash_seq_pkg::SEQ_IDLE;
            cmd     <= 8'h00;
            faddr   <= 16'h0000;
            run_cnt <= 15'h0000;
        end else if (err_stop || (err_any && state != flash_seq_pkg::SEQ_RUN)) begin
            state <= flash_seq_pkg::SEQ_IDLE;
        end else begin
            unique case (state)
                flash_seq_pkg::SEQ_IDLE: begin
                    if (w_addr && !key_hit && !drop && !accerr) begin
                        faddr <= PWDATA_I[15:0];
                        state <= flash_seq_pkg::SEQ_ADDR;
                    end
                end
                flash_seq_pkg::SEQ_ADDR: begin
                    if (w_cmd) begin
                        cmd   <= PWDATA_I[7:0];
                        state <= flash_seq_pkg::SEQ_CMD;
                    end
                end
                flash_seq_pkg::SEQ_CMD: begin
                    if (viol) begin
                        state <= flash_seq_pkg::SEQ_IDLE;
                    end else if (start) begin
                        state <= flash_seq_pkg::SEQ_RUN;
                        unique case (cmd)
                            `CMD_MASS:    run_cnt <= 15'(MASS_TICKS - 1);
                            `CMD_SECTOR:  run_cnt <= 15'(SECTOR_TICKS - 1);
                            `CMD_BURST:   run_cnt <= 15'(BURST_TICKS - 1);
                            `CMD_PROGRAM: run_cnt <= 15'(PROG_TICKS - 1);
                            default:      run_cnt <= 15'(VERIFY_TICKS - 1);
                        endcase
                    end
                end
                flash_seq_pkg::SEQ_RUN: begin
                    if (done) begin
                        state <= flash_seq_pkg::SEQ_IDLE;
                    end else if (tick) begin
                        run_cnt <= run_cnt - 15'h0001;
                    end
                end
            endcase
        end
    end

    // Error and violation flags; a new event wins over a clear.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            accerr <= 1'b0;
            pviol  <= 1'b0;
        end else begin
            if (err_any) begin
                accerr <= 1'b1;
            end else if (w_stat && PWDATA_I[`BIT_ACCERR]) begin
                accerr <= 1'b0;
            end
            if (viol) begin
                pviol <= 1'b1;
            end else if (w_stat && PWDATA_I[`BIT_PVIOL]) begin
                pviol <= 1'b0;
            end
        end
    end

    // Divider, options, protection and nonvolatile load after reset release.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            loaded  <= 1'b0;
            working_options_register    <= 8'h00;
            working_protection_register   <= 8'h00;
            divider <= 8'h00;
        end else begin
            if (!loaded) begin
                loaded <= 1'b1;
                working_options_register   <= NV_OPT_I;
                working_protection_register  <= NV_PROT_I;
            end else if (w_prot && DEBUG_I
                         && !in_seq) begin
                working_protection_register <= PWDATA_I[7:0];
            end
            if (w_div && !divider[`BIT_DIVLD] && !accerr && !in_seq) begin
                divider <= {1'b1, PWDATA_I[6:0]};
            end
        end
    end

    // Backdoor key entry and security state.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            key_access_bit   <= 1'b0;
            key_idx  <= 4'h0;
            key_ok   <= 1'b0;
            unlocked <= 1'b0;
            blank    <= 1'b0;
        end else begin
            if (w_cfg && trusted && !in_seq) begin
                key_access_bit <= PWDATA_I[`BIT_KEY_ACCESS_BIT];
                if (PWDATA_I[`BIT_KEY_ACCESS_BIT] && !key_access_bit) begin
                    key_idx <= 4'h0;
                    key_ok  <= 1'b1;
                end
                if (!PWDATA_I[`BIT_KEY_ACCESS_BIT] && key_access_bit && working_options_register[`BIT_BACKDOOR_ENABLE_BIT] && key_ok
                    && key_idx == `KEY_BYTES) begin
                    unlocked <= 1'b1;
                end
            end
            if (w_addr && key_hit && trusted) begin
                if (key_idx == `KEY_BYTES || PWDATA_I[2:0] != key_idx[2:0]
                    || PWDATA_I[23:16] != key_byte(NV_KEY_I, key_idx[2:0])) begin
                    key_ok <= 1'b0;
                end
                if (key_idx != `KEY_BYTES) begin
                    key_idx <= key_idx + 4'h1;
                end
            end
            if (start && cmd == `CMD_VERIFY) begin
                blank <= 1'b0;
            end
            if (done && cmd == `CMD_VERIFY && blank_s) begin
                blank    <= 1'b1;
                unlocked <= 1'b1;
            end
        end
    end

    // Bus answer with one wait state, registered outputs.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PREADY_O     <= 1'b0;
            PSLVERR_O    <= 1'b0;
            PRDATA_O     <= 32'h0000_0000;
            VEC_ADDR_O   <= 16'h0000;
            ARRAY_CMD_O  <= 8'h00;
            ARRAY_ADDR_O <= 16'h0000;
            SECURED_O    <= 1'b1;
        end else begin
            PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
            PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~mapped;
            PRDATA_O  <= 32'h0000_0000;
            unique case (PADDR_I)
                `OFS_DIVIDER:    PRDATA_O[7:0] <= divider;
                `OFS_OPTIONS:    PRDATA_O[7:0] <= working_options_register;
                `OFS_CONFIG:     PRDATA_O[`BIT_KEY_ACCESS_BIT] <= key_access_bit;
                `OFS_PROTECT:    PRDATA_O[7:0] <= working_protection_register;
                `OFS_STATUS:     PRDATA_O[7:0] <= {state != flash_seq_pkg::SEQ_RUN,
                                                   state != flash_seq_pkg::SEQ_RUN,
                                                   pviol, accerr, 1'b0, blank, 2'b00};
                `OFS_COMMAND:    PRDATA_O[7:0] <= cmd;
                `OFS_FLASH_ADDR: PRDATA_O[15:0] <= drop ? 16'h0000 : faddr;
                {`IDX_NV_PROT, 2'b00}: PRDATA_O[7:0] <= NV_PROT_I;
                {`IDX_NV_OPT, 2'b00}:  PRDATA_O[7:0] <= NV_OPT_I;
                default:         PRDATA_O <= 32'h0000_0000;
            endcase
            if (!working_options_register[`BIT_NORED] && any_prot && !full_prot
                && VEC_ADDR_I >= `VEC_LOW && VEC_ADDR_I <= `VEC_HIGH) begin
                VEC_ADDR_O <= {working_protection_register[7:1], VEC_ADDR_I[8:0]};
            end else begin
                VEC_ADDR_O <= VEC_ADDR_I;
            end
            ARRAY_CMD_O  <= (state == flash_seq_pkg::SEQ_RUN && !err_stop) ? cmd : 8'h00;
            ARRAY_ADDR_O <= {faddr[15:9], (cmd == `CMD_SECTOR) ? 9'h000 : faddr[8:0]};
            SECURED_O    <= secured;
        end
    end

    sequence s_launch;
        launch && !accerr;
    endsequence

    property p_ccf_clear;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        start |=> state == flash_seq_pkg::SEQ_RUN ##1 ARRAY_CMD_O == $past(cmd, 2);
    endproperty
    a_ccf_clear: assert property (p_ccf_clear) else $error("launch did not start run");

    property p_sector_viol;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        s_launch ##0 (cmd == `CMD_SECTOR && !working_protection_register[0] && faddr[15:9] > working_protection_register[7:1])
        |=> pviol && state == flash_seq_pkg::SEQ_IDLE ##1 ARRAY_CMD_O == 8'h00;
    endproperty
    a_sector_viol: assert property (p_sector_viol) else $error("protected sector launched");

    property p_mass_viol;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        s_launch ##0 (cmd == `CMD_MASS && any_prot) |=> pviol [*2];
    endproperty
    a_mass_viol: assert property (p_mass_viol) else $error("protected mass erase launched");

    property p_refuse;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (accerr && w_addr && state == flash_seq_pkg::SEQ_IDLE) |=> state == flash_seq_pkg::SEQ_IDLE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("command taken while error set");

    property p_no_div;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (w_addr && !key_hit && !drop && !divider[`BIT_DIVLD]) |=> accerr;
    endproperty
    a_no_div: assert property (p_no_div) else $error("address before divider not flagged");

    property p_bad_code;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (w_cmd && !cmd_valid(PWDATA_I[7:0])) |=> accerr && !in_seq;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("unknown code accepted");

    property p_stop;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (stop_s && state == flash_seq_pkg::SEQ_RUN) |=> accerr ##1 ARRAY_CMD_O == 8'h00;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort operation");

    property p_sec_dbg;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (w_cmd && DEBUG_I && secured && PWDATA_I[7:0] == `CMD_SECTOR) |=> accerr;
    endproperty
    a_sec_dbg: assert property (p_sec_dbg) else $error("secured debug erase accepted");

    property p_cancel;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (w_stat && in_seq && !PWDATA_I[`BIT_CBEF]) |=> accerr && !in_seq;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel did not raise error");

    property p_redirect;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (loaded && !working_options_register[`BIT_NORED] && any_prot && !full_prot && VEC_ADDR_I == `VEC_LOW)
        |=> VEC_ADDR_O[15:9] == $past(working_protection_register[7:1]) && VEC_ADDR_O[8:0] == 9'h1C0;
    endproperty
    a_redirect: assert property (p_redirect) else $error("vector not redirected");
endmodule // flash_seq
`default_nettype wire

// File: design/flash_seq_params.svh
// Register offsets, field positions, parameter defaults and command codes of the flash sequencer.
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define OFS_DIVIDER      18'h0_0000
`define OFS_OPTIONS      18'h0_0004
`define OFS_CONFIG       18'h0_0008
`define OFS_PROTECT      18'h0_000C
`define OFS_STATUS       18'h0_0010
`define OFS_COMMAND      18'h0_0014
`define OFS_FLASH_ADDR   18'h0_0018
`define IDX_NV_PROT      16'hFFBD
`define IDX_NV_OPT       16'hFFBF
`define BIT_CBEF         7
`define BIT_CCF          6
`define BIT_PVIOL        5
`define BIT_ACCERR       4
`define BIT_BLANK        2
`define BIT_KEY_ACCESS_BIT       5
`define BIT_DIVLD        7
`define BIT_PRDIV8       6
`define BIT_BACKDOOR_ENABLE_BIT        7
`define BIT_NORED        6
`define CMD_VERIFY       8'h05
`define CMD_PROGRAM      8'h20
`define CMD_BURST        8'h25
`define CMD_SECTOR       8'h40
`define CMD_MASS         8'h41
`define SEC_OPEN         2'h2
`define KEY_BASE         16'hFFB0
`define VEC_LOW          16'hFFC0
`define VEC_HIGH         16'hFFFD
`define LOW_ONES         9'h1FF
`define ALL_FPS          7'h7F
`define KEY_BYTES        4'h8
`define ARRAY_BASE_DEF   16'hF000
`define SECTOR_TICKS_DEF 4000
`define MASS_TICKS_DEF   20000
`define PROG_TICKS_DEF   9
`define BURST_TICKS_DEF  4
`define VERIFY_TICKS_DEF 16
`endif

// File: design/flash_seq_pkg.sv
// Types shared by the flash sequencer.
`default_nettype none
package flash_seq_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ADDR = 2'b01,
        SEQ_CMD  = 2'b10,
        SEQ_RUN  = 2'b11
    } seq_state_t;
endpackage
`default_nettype wire

// File: dv/flash_bus_model.sv
// Bus master model standing in for the CPU and the debug controller.
`default_nettype none
module flash_bus_model (
    input  wire logic        clk_i,
    input  wire logic        rdy_i,
    input  wire logic [31:0] rdata_i,
    output logic             sel_o,
    output logic             en_o,
    output logic             wr_o,
    output logic      [17:0] addr_o,
    output logic      [31:0] wdata_o,
    output logic      [1:0]  src_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {sel_o, en_o, wr_o, addr_o, wdata_o, src_o} = '0;
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                        input logic [1:0] s, output logic [31:0] q);
        {sel_o, wr_o, addr_o, wdata_o, src_o} <= {1'b1, w, a, d, s};
        @(posedge clk_i);
        en_o <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (rdy_i !== 1'b1);
        q = rdata_i;
        {sel_o, en_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
        @(posedge clk_i);
    endtask
endmodule // flash_bus_model
`default_nettype wire

// File: dv/flash_erase_protect_security_test.sv
// Self-checking bench for the flash command sequencer.
`default_nettype none
`include "flash_seq_params.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module flash_erase_protect_security_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        stop = 1'b0;
    logic        blank_in = 1'b0;
    logic        sel, en, wr_en, rdy, secured;
    logic [1:0]  src;
    logic [17:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] vin = 16'hFFC0;
    logic [15:0] vout, aaddr;
    logic [7:0]  acmd;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [63:0] key = 64'h0123_4567_89AB_CDEF;
    always #10 clk = ~clk;
    flash_seq #(.SECTOR_TICKS(4), .MASS_TICKS(6), .VERIFY_TICKS(4)) dut (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(sel), .PENABLE_I(en),
        .PWRITE_I(wr_en), .PADDR_I(addr), .PWDATA_I(wdata), .PRDATA_O(rdata),
        .PREADY_O(rdy), .PSLVERR_O(), .DEBUG_I(src[1]), .SECURE_SRC_I(src[0]),
        .STOP_I(stop), .BLANK_I(blank_in), .NV_PROT_I(8'hF8), .NV_OPT_I(8'h83),
        .NV_KEY_I(key), .VEC_ADDR_I(vin), .VEC_ADDR_O(vout), .ARRAY_CMD_O(acmd),
        .ARRAY_ADDR_O(aaddr), .SECURED_O(secured));
    flash_bus_model host (.clk_i(clk), .rdy_i(rdy), .rdata_i(rdata), .sel_o(sel),
        .en_o(en), .wr_o(wr_en), .addr_o(addr), .wdata_o(wdata), .src_o(src));
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] s = 2'b01);
        logic [31:0] q;
        host.xfer(1'b1, a, d, s, q);
    endtask
    task automatic launch(input logic [15:0] a, input logic [7:0] c, input logic [1:0] s);
        wr(`OFS_FLASH_ADDR, {16'h0000, a}, s);
        wr(`OFS_COMMAND, {24'h00_0000, c}, s);
        wr(`OFS_STATUS, 32'h0000_0080, s);
        @(posedge clk);
    endtask
    task automatic stat(input logic [3:0] e);
        logic [31:0] q;
        host.xfer(1'b0, `OFS_STATUS, 32'h0000_0000, 2'b01, q);
        `CHK("status", e, q[7:4])
    endtask
    task automatic done();
        logic [31:0] q;
        q = '0;
        for (int i = 0; i < 40 && q[6] !== 1'b1; i++) host.xfer(1'b0, `OFS_STATUS, '0, 2'b01, q);
    endtask
    task automatic t_vec();
        repeat (3) @(posedge clk);
        `CHK("vector", 16'hF9C0, vout)
        `CHK("secured", 1'b1, secured)
        vin <= 16'hFFFE;
        repeat (2) @(posedge clk);
        `CHK("reset vector", 16'hFFFE, vout)
        $display("test vec done");
    endtask
    task automatic t_err();
        wr(`OFS_FLASH_ADDR, 32'h0000_F200);
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        stat(4'hC);
        wr(`OFS_DIVIDER, 32'h0000_0009);
        launch(16'hF200, 8'h33, 2'b01);
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        wr(`OFS_FLASH_ADDR, 32'h0000_F200);
        wr(`OFS_CONFIG, 32'h0000_0000);
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        wr(`OFS_FLASH_ADDR, 32'h0000_F200);
        wr(`OFS_FLASH_ADDR, 32'h0000_F200);
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        wr(`OFS_FLASH_ADDR, 32'h0000_F200);
        wr(`OFS_COMMAND, 32'h0000_0040);
        wr(`OFS_STATUS, 32'h0000_0000);
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        $display("test err done");
    endtask
    task automatic t_erase();
        launch(16'hF3A5, `CMD_SECTOR, 2'b01);
        `CHK("cmd", `CMD_SECTOR, acmd)
        `CHK("addr", 16'hF200, aaddr)
        stat(4'h0);
        wr(`OFS_FLASH_ADDR, 32'h0000_F400);
        stat(4'h1);
        done();
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        launch(16'hFC00, `CMD_SECTOR, 2'b01);
        `CHK("cmd", 8'h00, acmd)
        stat(4'hE);
        wr(`OFS_STATUS, 32'h0000_0020);
        $display("test erase done");
    endtask
    task automatic t_debug();
        logic [31:0] q;
        launch(16'hF200, `CMD_MASS, 2'b01);
        stat(4'hE);
        wr(`OFS_STATUS, 32'h0000_0020);
        wr(`OFS_PROTECT, 32'h0000_00FF);
        host.xfer(1'b0, `OFS_PROTECT, '0, 2'b01, q);
        `CHK("protect", 8'hF8, q[7:0])
        wr(`OFS_PROTECT, 32'h0000_00FF, 2'b10);
        host.xfer(1'b0, `OFS_PROTECT, '0, 2'b01, q);
        `CHK("protect", 8'hFF, q[7:0])
        launch(16'hF200, `CMD_PROGRAM, 2'b10);
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        launch(16'hF000, `CMD_MASS, 2'b10);
        `CHK("cmd", `CMD_MASS, acmd)
        done();
        stat(4'hC);
        launch(16'hF200, `CMD_SECTOR, 2'b01);
        stop <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("cmd", 8'h00, acmd)
        stop <= 1'b0;
        stat(4'hD);
        wr(`OFS_STATUS, 32'h0000_0030);
        $display("test debug done");
    endtask
    task automatic t_key();
        logic [31:0] q;
        wr(`OFS_CONFIG, 32'h0000_0020);
        for (int i = 0; i < 8; i++) wr(`OFS_FLASH_ADDR, {8'h00, key[63-8*i -: 8], 16'hFFB0 + 16'(i)});
        wr(`OFS_CONFIG, 32'h0000_0000);
        repeat (2) @(posedge clk);
        `CHK("secured", 1'b0, secured)
        blank_in <= 1'b1;
        launch(16'hF000, `CMD_VERIFY, 2'b10);
        done();
        host.xfer(1'b0, `OFS_STATUS, '0, 2'b01, q);
        `CHK("blank", 1'b1, q[2])
        $display("test key done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_vec();
        t_err();
        t_erase();
        t_debug();
        t_key();
        end_sim();
    end
endmodule // flash_erase_protect_security_test
`default_nettype wire
